// ==== logic/plrc_defines.vh ====
`ifndef PLRC_DEFINES_VH
`define PLRC_DEFINES_VH

// ---------------------------------------------------------------
// Register byte offsets (word aligned)
// ---------------------------------------------------------------
`define PLRC_OFS_SLEEP     6'h00
`define PLRC_OFS_PERF      6'h04
`define PLRC_OFS_IRQCLR    6'h08
`define PLRC_OFS_IRQSET    6'h0C
`define PLRC_OFS_IRQFLAG   6'h10
`define PLRC_OFS_REGSYS    6'h14
`define PLRC_OFS_STDBY     6'h18
`define PLRC_OFS_STATUS    6'h1C
`define PLRC_ADDR_W        6

// ---------------------------------------------------------------
// Field codes and reset values
// ---------------------------------------------------------------
`define PLRC_SLP_IDLE      3'h2
`define PLRC_SLP_STANDBY   3'h4
`define PLRC_SLP_BACKUP    3'h5
`define PLRC_SLP_OFF       3'h6
`define PLRC_PL_LOW        2'h0
`define PLRC_PL_HIGH       2'h2
`define PLRC_SMOD_AUTO     2'h0
`define PLRC_SMOD_PERF     2'h1
`define PLRC_SMOD_LP       2'h2
`define PLRC_RST_SLEEP     3'h2
`define PLRC_RST_STEP      4'h0
`define PLRC_RST_PER       3'h0

// Register-system bit positions
`define PLRC_RS_SEL        0
`define PLRC_RS_LOWPOWER_REGULATOR_EFFICIENCY      1
`define PLRC_RS_STEP_LO    4
`define PLRC_RS_STEP_HI    7
`define PLRC_RS_PER_LO     8
`define PLRC_RS_PER_HI     10

// ---------------------------------------------------------------
// Voltage ramp: base step 5 mV, base period 1 us at 40 MHz
// ---------------------------------------------------------------
`define PLRC_STEP_MV       12'd5
`define PLRC_CLK_MHZ       40
`define PLRC_PER_NS        1000
`define PLRC_CLK_NS        25
// One base period of 1 us is 40 cycles of the 25 ns clock
`define PLRC_PER_CYC       16'd40
`define PLRC_VLOW_MV       12'd900
`define PLRC_VHIGH_MV      12'd1200
`define PLRC_VSTBY_MV      12'd800
`define PLRC_CNT_W         16

`endif

// ==== logic/plrc_perf_ctrl.v ====
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`include "plrc_defines.vh"

// Notes on behaviour
// - Sleep request with off code 0x6 stops all regulators, oscillators and peripherals.
// - Off state left only by pin reset or power-on reset, never by interrupts.
// - Level select 0x0 gives low core voltage; 0x2 gives highest voltage.
// - Level change never touches oscillator, prescaler or clock generator settings.
// - Ready flag sets after voltage settles; software waits before raising clock. Code sets it only when an upward ramp settles.
// - Ready flag raises interrupt when its enable was set via enable-set register.
// - Main regulator feeds core in active and idle; standby uses main or low-power.
// - Main regulator starts on linear stage; select bit switches to buck stage.
// - Standby with domains active keeps low-power regulator unless mode is performance, or auto with a task and clocks requested.
// - Standby uses low-power regulator when mode two, or auto with no task.
// - Core voltage ramps in steps on level change, standby entry/exit, task start.
// - Step height resets to zero meaning 5mV; higher codes give larger steps.
// - Step period resets to zero meaning 1us; other codes set longer delays.
// - Sleep codes: idle 0x2, standby 0x4, backup 0x5, alongside off.
module plrc_perf_ctrl (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Processor and system events
  input  wire        waitForInterruptInstr,
  input  wire        wakeIrq,
  input  wire        domainsActive,
  input  wire        clocksRequested,
  input  wire        autonomousTask,
  // Power outputs
  output reg  [2:0]  sleepState,
  output reg         deviceOff,
  output reg         mainRegulatorOn,
  output reg         lowpowerRegulatorOn,
  output reg         buckSelected,
  output reg  [11:0] coreSupplyMv,
  output wire        irq
);

  // ---------------------------------------------------------------
  // Sleep state codes
  // ---------------------------------------------------------------
  localparam [2:0] ST_ACTIVE = 3'h0;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [2:0]             sleepStateSelect;
  reg  [1:0]             perfLevelSelect;
  reg                    irqEnable;
  reg                    perfLevelReadyFlag;
  reg                    regSel;
  reg                    lowpower_regulator_efficiency;
  reg  [3:0]             stepHeight;
  reg  [2:0]             stepPeriod;
  reg  [1:0]             switchMode;
  reg                    ackReg;
  reg  [11:0]            targetMv;
  reg  [`PLRC_CNT_W-1:0] stepCnt;
  reg                    ramping;
  reg                    rampWasUp;
  reg  [11:0]            next_target;

  wire                   busReq   = wb_cyc_i & wb_stb_i;
  // Writes land on the edge that ends the ack cycle, while the request still stands
  wire                   wrStrobe = busReq & wb_we_i & ackReg & wb_sel_i[0];
  wire                   wrHi     = busReq & wb_we_i & ackReg & wb_sel_i[1];
  // Off entry cuts the supplies on the same edge that raises deviceOff
  wire                   offEntry = (sleepState == ST_ACTIVE) & waitForInterruptInstr &
                                    (sleepStateSelect == `PLRC_SLP_OFF);
  wire [11:0]            stepMv;
  wire [`PLRC_CNT_W-1:0] perCycles;
  wire                   inStandby = (sleepState == `PLRC_SLP_STANDBY);
  wire                   rampDone;
  wire                   readySet;

  assign wb_ack_o = ackReg;

  // Step height scales the 5 mV base step linearly
  assign stepMv = (stepHeight + 12'd1) * `PLRC_STEP_MV;

  // Period code doubles the 1 us base delay per code
  assign perCycles = `PLRC_PER_CYC << stepPeriod;

  // ---------------------------------------------------------------
  // Ramp target selection
  // ---------------------------------------------------------------
  // Standby drops to retention voltage unless a task needs the level
  always @* begin
    if (inStandby && !autonomousTask) begin
      next_target = `PLRC_VSTBY_MV;
    end else if (perfLevelSelect == `PLRC_PL_HIGH) begin
      next_target = `PLRC_VHIGH_MV;
    end else begin
      next_target = `PLRC_VLOW_MV;
    end
  end

  assign rampDone = (coreSupplyMv == targetMv);
  // Ready only on completion of an upward ramp, so software can wait on it
  assign readySet = ramping & rampDone & rampWasUp;

  // ---------------------------------------------------------------
  // Wishbone slave: one registered ack per request, a cycle after the strobe
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= busReq & ~ackReg;
    end
  end

  // Read mux; unmapped offsets read zero
  always @(posedge clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (busReq && !wb_we_i && !ackReg) begin
      case (wb_adr_i)
        `PLRC_OFS_SLEEP:   wb_dat_o <= {29'h0, sleepStateSelect};
        `PLRC_OFS_PERF:    wb_dat_o <= {30'h0, perfLevelSelect};
        `PLRC_OFS_IRQCLR:  wb_dat_o <= {31'h0, irqEnable};
        `PLRC_OFS_IRQSET:  wb_dat_o <= {31'h0, irqEnable};
        `PLRC_OFS_IRQFLAG: wb_dat_o <= {31'h0, perfLevelReadyFlag};
        `PLRC_OFS_REGSYS:  wb_dat_o <= {21'h0, stepPeriod, stepHeight, 2'h0, lowpower_regulator_efficiency, regSel};
        `PLRC_OFS_STDBY:   wb_dat_o <= {30'h0, switchMode};
        `PLRC_OFS_STATUS:  wb_dat_o <= {19'h0, coreSupplyMv, ramping};
        default:           wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Only power-management fields live here; clock settings are untouched
  always @(posedge clk) begin
    if (sys_rst) begin
      sleepStateSelect <= `PLRC_RST_SLEEP;
      perfLevelSelect  <= `PLRC_PL_HIGH;
      irqEnable        <= 1'b0;
      regSel           <= 1'b0;
      lowpower_regulator_efficiency            <= 1'b0;
      stepHeight       <= `PLRC_RST_STEP;
      stepPeriod       <= `PLRC_RST_PER;
      switchMode       <= `PLRC_SMOD_AUTO;
    end else if (wrStrobe) begin
      case (wb_adr_i)
        `PLRC_OFS_SLEEP:  sleepStateSelect <= wb_dat_i[2:0];
        `PLRC_OFS_PERF: begin
          // Only two levels exist; other codes are ignored
          if (wb_dat_i[1:0] == `PLRC_PL_LOW || wb_dat_i[1:0] == `PLRC_PL_HIGH) begin
            perfLevelSelect <= wb_dat_i[1:0];
          end
        end
        `PLRC_OFS_IRQSET: if (wb_dat_i[0]) irqEnable <= 1'b1;
        `PLRC_OFS_IRQCLR: if (wb_dat_i[0]) irqEnable <= 1'b0;
        `PLRC_OFS_REGSYS: begin
          regSel     <= wb_dat_i[`PLRC_RS_SEL];
          lowpower_regulator_efficiency      <= wb_dat_i[`PLRC_RS_LOWPOWER_REGULATOR_EFFICIENCY];
          stepHeight <= wb_dat_i[`PLRC_RS_STEP_HI:`PLRC_RS_STEP_LO];
        end
        `PLRC_OFS_STDBY:  switchMode <= wb_dat_i[1:0];
        default: ;
      endcase
    end
    if (!sys_rst && wrHi && wb_adr_i == `PLRC_OFS_REGSYS) begin
      stepPeriod <= wb_dat_i[`PLRC_RS_PER_HI:`PLRC_RS_PER_LO];
    end
  end

  // Ready flag: hardware set wins over a write-one clear
  always @(posedge clk) begin
    if (sys_rst) begin
      perfLevelReadyFlag <= 1'b0;
    end else if (readySet) begin
      perfLevelReadyFlag <= 1'b1;
    end else if (wrStrobe && wb_adr_i == `PLRC_OFS_IRQFLAG && wb_dat_i[0]) begin
      perfLevelReadyFlag <= 1'b0;
    end
  end

  // Level interrupt while the unmasked flag stands
  assign irq = perfLevelReadyFlag & irqEnable;

  // ---------------------------------------------------------------
  // Sleep state machine
  // ---------------------------------------------------------------
  // Off is absorbing: only sys_rst (pin or power-on reset) leaves it
  always @(posedge clk) begin
    if (sys_rst) begin
      sleepState <= ST_ACTIVE;
      deviceOff  <= 1'b0;
    end else begin
      case (sleepState)
        ST_ACTIVE: begin
          if (waitForInterruptInstr) begin
            case (sleepStateSelect)
              `PLRC_SLP_IDLE, `PLRC_SLP_STANDBY, `PLRC_SLP_BACKUP:
                sleepState <= sleepStateSelect;
              `PLRC_SLP_OFF: begin
                sleepState <= `PLRC_SLP_OFF;
                deviceOff  <= 1'b1;
              end
              default: ;
            endcase
          end
        end
        `PLRC_SLP_IDLE, `PLRC_SLP_STANDBY: begin
          if (wakeIrq) sleepState <= ST_ACTIVE;
        end
        `PLRC_SLP_BACKUP: begin
          if (wakeIrq) sleepState <= ST_ACTIVE;
        end
        `PLRC_SLP_OFF: sleepState <= `PLRC_SLP_OFF;
        default: sleepState <= ST_ACTIVE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Regulator selection
  // ---------------------------------------------------------------
  // Low-power regulator only in standby, when the mode allows it or no domain is active
  always @(posedge clk) begin
    if (sys_rst) begin
      mainRegulatorOn     <= 1'b1;
      lowpowerRegulatorOn <= 1'b0;
      buckSelected        <= 1'b0;
    end else begin
      buckSelected <= regSel & ~deviceOff & ~offEntry;
      case (sleepState)
        `PLRC_SLP_OFF, `PLRC_SLP_BACKUP: begin
          mainRegulatorOn     <= 1'b0;
          lowpowerRegulatorOn <= 1'b0;
        end
        `PLRC_SLP_STANDBY: begin
          if (switchMode == `PLRC_SMOD_LP ||
              (switchMode == `PLRC_SMOD_AUTO && !autonomousTask) ||
              (switchMode != `PLRC_SMOD_PERF && !clocksRequested) ||
              !domainsActive) begin
            mainRegulatorOn     <= 1'b0;
            lowpowerRegulatorOn <= 1'b1;
          end else begin
            mainRegulatorOn     <= 1'b1;
            lowpowerRegulatorOn <= 1'b0;
          end
        end
        default: begin
          mainRegulatorOn     <= ~offEntry;
          lowpowerRegulatorOn <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Stepped voltage ramp
  // ---------------------------------------------------------------
  // Steps limit inrush current at the cost of a longer transition
  always @(posedge clk) begin
    if (sys_rst) begin
      coreSupplyMv <= `PLRC_VHIGH_MV;
      targetMv     <= `PLRC_VHIGH_MV;
      stepCnt      <= {`PLRC_CNT_W{1'b0}};
      ramping      <= 1'b0;
      rampWasUp    <= 1'b0;
    end else if (deviceOff) begin
      coreSupplyMv <= 12'h000;
      ramping      <= 1'b0;
    end else begin
      if (next_target != targetMv) begin
        // New trigger: level change, standby edge or task start
        targetMv  <= next_target;
        rampWasUp <= (next_target > coreSupplyMv);
        ramping   <= 1'b1;
        stepCnt   <= perCycles;
      end else if (ramping) begin
        if (rampDone) begin
          ramping <= 1'b0;
        end else if (stepCnt > 1) begin
          stepCnt <= stepCnt - 1'b1;
        end else begin
          stepCnt <= perCycles;
          if (coreSupplyMv < targetMv) begin
            coreSupplyMv <= (targetMv - coreSupplyMv > stepMv) ?
                            coreSupplyMv + stepMv : targetMv;
          end else begin
            coreSupplyMv <= (coreSupplyMv - targetMv > stepMv) ?
                            coreSupplyMv - stepMv : targetMv;
          end
        end
      end
    end
  end

endmodule // plrc_perf_ctrl

// ==== sim/plrc_perf_ctrl_props.sv ====
`timescale 1ns/100ps
module plrc_perf_ctrl_props (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // Bus handshake
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  // Power state
  input wire [2:0]  sleepState,
  input wire        deviceOff,
  input wire        mainRegulatorOn,
  input wire        lowpowerRegulatorOn,
  input wire [11:0] coreSupplyMv
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------
  // Bus handshake
  // ----------------
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // ----------------
  // Sleep states
  // ----------------
  a_off_sticky: assert property (deviceOff |=> deviceOff)
    else $error("off state left without reset");
  a_off_no_supply: assert property (deviceOff |-> !mainRegulatorOn && !lowpowerRegulatorOn)
    else $error("regulator running in off state");
  a_off_state_code: assert property (deviceOff |-> sleepState == 3'h6)
    else $error("off flag and state code disagree");
  a_sleep_codes_legal: assert property (sleepState inside {3'h0, 3'h2, 3'h4, 3'h5, 3'h6})
    else $error("illegal sleep state code");
  // Steps are spaced by more than eight cycles and never exceed the largest height
  a_step_spacing: assert property ($changed(coreSupplyMv) && sleepState < 3'h5 |=> $stable(coreSupplyMv)[*8])
    else $error("voltage steps too close");
  a_step_height: assert property ($changed(coreSupplyMv) && sleepState < 3'h5 |->
    (coreSupplyMv > $past(coreSupplyMv) ? coreSupplyMv - $past(coreSupplyMv)
      : $past(coreSupplyMv) - coreSupplyMv) <= 12'h050)
    else $error("voltage step too large");
endmodule // plrc_perf_ctrl_props

bind plrc_perf_ctrl plrc_perf_ctrl_props u_props (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sleepState(sleepState),
  .deviceOff(deviceOff), .mainRegulatorOn(mainRegulatorOn),
  .lowpowerRegulatorOn(lowpowerRegulatorOn), .coreSupplyMv(coreSupplyMv));

// ==== sim/plrc_perf_ctrl_tb.sv ====
`timescale 1ns/100ps
module plrc_perf_ctrl_tb;
  logic        clk = 1'b0, sysRst = 1'b1, domAct = 1'b0;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wait_for_interrupt_instr = 1'b0, wakeIrq = 1'b0;
  logic        autoTask = 1'b0, clkReq = 1'b0;
  logic [3:0]  wbSel = 4'hF;
  logic [5:0]  wbAdr = 6'h00;
  logic [31:0] wbDatI = 32'h0000_0000, wbDatO, cfg;
  logic        wbAck, deviceOff, mainOn, lpOn, buckSel, irq;
  logic [2:0]  sleepState, p;
  logic [3:0]  h;
  logic [11:0] coreMv;
  logic [31:0] expQ[$];
  logic [2:0]  codes[4] = '{3'h2, 3'h4, 3'h5, 3'h6};
  int          err_count = 0, compares = 0, cycles = 0, n, per, steps;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  plrc_perf_ctrl uut (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .waitForInterruptInstr(wait_for_interrupt_instr), .wakeIrq(wakeIrq), .domainsActive(domAct),
    .clocksRequested(clkReq), .autonomousTask(autoTask), .sleepState(sleepState),
    .deviceOff(deviceOff), .mainRegulatorOn(mainOn), .lowpowerRegulatorOn(lpOn),
    .buckSelected(buckSel), .coreSupplyMv(coreMv), .irq(irq));

  task close_out;
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chkBus(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: read %0h, expected %0h", $time, got, exp);
    end
  endtask

  task chkOut(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: output %0h, expected %0h", $time, got, exp);
    end
  endtask

  // Read data is only judged at the ack edge, against the oldest noted value
  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
      chkBus(wbDatO, expQ.pop_front());
    end
  end

  // Hang guard: ramps and sleep loop need well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      close_out();
    end
  end

  // Classic cycle; for a read d is the value the bus should return
  task wbXfer(input logic we, input logic [5:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    if (!we) expQ.push_back(d);
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("Error at %0t: no ack", $time);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task doReset;
    sysRst <= 1'b1;
    repeat (8) @(posedge clk);
    sysRst <= 1'b0;
  endtask

  // Waits for a voltage, then checks it and the step count of the ramp
  task rampTo(input logic [11:0] target);
    n = 0;
    while (coreMv !== target && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chkOut(coreMv, target);
    chkOut(12'((n + 8) / per), 12'(steps));
  endtask

  // Enters standby under one mode and context, checks the regulators, then wakes
  task stbyRun(input logic [1:0] mode, input logic tsk, input logic clkOn,
               input logic [1:0] expReg);
    wbXfer(1'b1, 6'h18, {30'h00000000, mode});
    wbXfer(1'b1, 6'h00, 32'h0000_0004);
    autoTask <= tsk;
    clkReq <= clkOn;
    domAct <= 1'b1;
    @(posedge clk);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge clk);
    wait_for_interrupt_instr <= 1'b0;
    repeat (3) @(posedge clk);
    chkOut({10'h000, mainOn, lpOn}, {10'h000, expReg});
    wakeIrq <= 1'b1;
    repeat (3) @(posedge clk);
    wakeIrq <= 1'b0;
    autoTask <= 1'b0;
    chkOut(12'(sleepState), 12'h000);
  endtask

  initial begin
    void'($urandom(32'h00B8));
    h = 4'($urandom % 16);
    p = 3'($urandom % 2);
    doReset;
    domAct <= 1'($urandom % 2);
    wbXfer(1'b0, 6'h00, 32'h0000_0002);
    wbXfer(1'b0, 6'h04, 32'h0000_0002);
    wbXfer(1'b0, 6'h14, 32'h0000_0000);
    wbXfer(1'b0, 6'h3C, 32'h0000_0000);
    chkOut({11'h000, buckSel}, 12'h000);
    chkOut(coreMv, 12'h4B0);
    $display("Test reset values done");
    // Efficiency bit stays off: the supply range is not known to be narrow
    cfg = {21'h000000, p, h, 4'h1};
    wbXfer(1'b1, 6'h14, cfg);
    wbXfer(1'b0, 6'h14, cfg);
    // Lane 0 alone must leave the period field, which sits in lane 1
    wbSel <= 4'h1;
    wbXfer(1'b1, 6'h14, cfg ^ 32'h0000_0700);
    wbSel <= 4'hF;
    wbXfer(1'b0, 6'h14, cfg);
    repeat (2) @(posedge clk);
    chkOut({11'h000, buckSel}, 12'h001);
    $display("Test regulator config done");
    per = 40 << p;
    steps = (300 + (h + 1) * 5 - 1) / ((h + 1) * 5);
    // Software has already slowed clocks and set wait states for the lower level
    wbXfer(1'b1, 6'h04, 32'h0000_0000);
    rampTo(12'h384);
    wbXfer(1'b1, 6'h04, 32'h0000_0001);
    wbXfer(1'b0, 6'h04, 32'h0000_0000);
    chkOut({11'h000, irq}, 12'h000);
    wbXfer(1'b1, 6'h0C, 32'h0000_0001);
    // Wait states are taken as raised before the level goes up
    wbXfer(1'b1, 6'h04, 32'h0000_0002);
    rampTo(12'h4B0);
    repeat (2) @(posedge clk);
    chkOut({11'h000, irq}, 12'h001);
    wbXfer(1'b1, 6'h10, 32'h0000_0000);
    wbXfer(1'b0, 6'h10, 32'h0000_0001);
    wbXfer(1'b1, 6'h08, 32'h0000_0001);
    @(posedge clk);
    chkOut({11'h000, irq}, 12'h000);
    wbXfer(1'b1, 6'h10, 32'h0000_0001);
    wbXfer(1'b0, 6'h10, 32'h0000_0000);
    $display("Test level change done");
    stbyRun(2'h1, 1'b0, 1'b0, 2'b10);
    stbyRun(2'h0, 1'b1, 1'b0, 2'b01);
    stbyRun(2'h0, 1'b1, 1'b1, 2'b10);
    stbyRun(2'h0, 1'b0, 1'b1, 2'b01);
    $display("Test standby regulators done");
    foreach (codes[i]) begin
      wbXfer(1'b1, 6'h18, 32'h0000_0002);
      wbXfer(1'b1, 6'h00, {29'h00000000, codes[i]});
      @(posedge clk);
      wait_for_interrupt_instr <= 1'b1;
      @(posedge clk);
      wait_for_interrupt_instr <= 1'b0;
      wakeIrq <= (codes[i] == 3'h6);
      @(posedge clk);
      chkOut(12'(sleepState), 12'(codes[i]));
      n = 0;
      while (codes[i] == 3'h4 && lpOn !== 1'b1 && n < 9000) begin
        @(posedge clk);
        n++;
      end
      if (codes[i] == 3'h4) chkOut({11'h000, lpOn}, 12'h001);
      if (codes[i] == 3'h6) begin
        repeat (4) @(posedge clk);
        chkOut({9'h000, deviceOff, mainOn, lpOn}, 12'h004);
        chkOut(12'(sleepState), 12'h006);
      end
      wakeIrq <= 1'b0;
      doReset;
      @(posedge clk);
      chkOut(12'(sleepState), 12'h000);
    end
    $display("Test sleep codes done");
    close_out();
  end
endmodule // plrc_perf_ctrl_tb
